// >>> aim_pkg.sv
package aim_pkg;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TENTH_SEC_NS = 100_000_000;
  localparam int TENTH_SEC_CYC = TENTH_SEC_NS / CLK_PERIOD_NS;

  // Register index space; byte address is four times the index.
  localparam int IDX_W = 16;
  localparam int NCFG = 22;
  localparam int S_OVL_FLT = 0;
  localparam int S_DEV_FLT = 1;
  localparam int S_DRV_TMP = 2;
  localparam int S_OL_TIME = 3;
  localparam int S_SPEED = 4;
  localparam int S_DEV_ADV = 5;
  localparam int S_MTR_TMP = 6;
  localparam int S_AC_OV = 7;
  localparam int S_AC_UV = 8;
  localparam int S_DC_OV = 9;
  localparam int S_DC_UV = 10;
  localparam int S_TRIP = 11;
  localparam int S_ODO = 12;
  localparam int S_LOAD_A = 13;
  localparam int S_LOAD_B = 14;
  localparam int S_LOAD_ZERO = 15;
  localparam int S_LOAD_DIV = 16;
  localparam int S_USR_SEL = 17;
  localparam int S_USR_INV = 18;
  localparam int S_NET_EN = 19;
  localparam int S_ADV_AUTO = 20;
  localparam int S_ADV_ACT = 21;
  localparam logic [IDX_W-1:0] CFG_IDX [NCFG] = '{
    16'h0180, 16'h0181, 16'h01a0, 16'h01a1, 16'h01a2, 16'h01a5,
    16'h01a8, 16'h01a9, 16'h01aa, 16'h01ab, 16'h01ac, 16'h01af,
    16'h01b0, 16'h01b1, 16'h01b2, 16'h01b3, 16'h01b4, 16'h01bc,
    16'h01bd, 16'h6188, 16'h01bf, 16'h01c0};
  localparam logic [31:0] CFG_RST [NCFG] = '{
    32'h32, 32'h12c, 32'h55, 32'h32, 32'h0, 32'h12c,
    32'h55, 32'h1b3, 32'h78, 32'h276, 32'hb4, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h80,
    32'h0, 32'h1, 32'h1, 32'hfff};
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'h01c1;
  localparam logic [IDX_W-1:0] IDX_LOAD = 16'h01c2;

  // Status word fields.
  localparam int ST_FAULT_BIT = 8;
  localparam int ST_ADV_LSB = 16;

  // Advisory event bits.
  localparam int NADV = 12;
  localparam int A_USR = 0;
  localparam int A_DEV = 1;
  localparam int A_DRV = 2;
  localparam int A_MTR = 3;
  localparam int A_OV = 4;
  localparam int A_UV = 5;
  localparam int A_OLT = 6;
  localparam int A_SPD = 7;
  localparam int A_LDA = 8;
  localparam int A_LDB = 9;
  localparam int A_TRIP = 10;
  localparam int A_ODO = 11;

  // Fault codes and user source selection.
  localparam logic [7:0] CODE_COMBO = 8'h45;
  localparam logic [7:0] CODE_NET = 8'h81;
  localparam int USR_SRC_N = 128;

  typedef enum logic {ST_RUN, ST_FAULT} aim_fault_state_e;

  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  function automatic logic at_or_above(input logic [31:0] v,
                                       input logic [31:0] lim);
    return v >= lim;
  endfunction : at_or_above

endpackage : aim_pkg

// >>> aim_advisory_flag.sv
module aim_advisory_flag (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Event control.
  input wire logic cond_i,
  input wire logic action_i,
  input wire logic auto_clear_i,
  input wire logic clear_i,
  // Flag outputs.
  output logic flag_o,
  output logic reflect_o
);

  logic flag_q;

  // A live cause beats both automatic and software clearing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (cond_i) begin
      flag_q <= 1'b1;
    end else if (auto_clear_i || clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
  assign reflect_o = flag_q & action_i;

endmodule : aim_advisory_flag

// >>> aim_led_blink.sv
module aim_led_blink (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pattern control.
  input wire logic tick_i,
  input wire logic fault_i,
  input wire logic blink_i,
  // Indicator.
  output logic led_red_o,
  output logic led_green_o
);

  logic [2:0] phase_q;
  logic red_q;
  logic green_q;
  wire blink_on = (phase_q == 3'h0) || (phase_q == 3'h2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 3'h0;
    end else if (!blink_i) begin
      phase_q <= 3'h0;
    end else if (tick_i) begin
      phase_q <= phase_q + 3'h1;
    end
  end

  // Both colours share the two pulses, so they may look orange.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      red_q <= 1'b0;
      green_q <= 1'b0;
    end else if (fault_i) begin
      red_q <= 1'b1;
      green_q <= 1'b0;
    end else if (blink_i) begin
      red_q <= blink_on;
      green_q <= blink_on;
    end else begin
      red_q <= 1'b0;
      green_q <= 1'b1;
    end
  end

  assign led_red_o = red_q;
  assign led_green_o = green_q;

endmodule : aim_led_blink

// >>> aim_alarm_info_monitor.sv
// Function
// - Overload fault after overload lasts the set count of tenth seconds.
// - Deviation fault once deviation reaches the programmed limit.
// - Network bus fault enabled by setting one, disabled by zero.
// - Combination fault, code 45h, on motor and driver supply mismatch.
// - DC driver faults on small frame motor with 48 V applied.
// - Fault drops no-fault, motion and pulse-ready outputs, stops motor.
// - Fault clear input clears a removed fault and restores outputs.
// - Each advisory event raises its own flag output.
// - User flag follows one selected output signal; 128 means off.
// - Invert bit flips the user flag logic.
// - Advisory events raise the common advisory output.
// - Advisory events blink the LED red and green twice.
// - Advisory events never stop the motor.
// - Action zero raises only the event flag.
// - Driver and motor temperature advisories at programmed limits.
// - Overload time and deviation advisories at programmed limits.
// - Speed advisory at its limit; zero disables it.
// - Voltage advisories use AC or DC limits per driver type.
// - Trip and total distance advisories; zero disables each.
// - Accumulated load divided by divisor, compared with two limits.
// - Auto clear zeroes accumulated load on motion start.
// - Action one raises flag, common output and LED blink.
// - Advisory auto clear drops flags once the cause is gone.
//
// Local design decision: register access over Wishbone.
module aim_alarm_info_monitor
  import aim_pkg::*;
#(
  parameter int ADR_W = 18,
  parameter int TICK_CYCLES = TENTH_SEC_CYC,
  parameter logic [7:0] OVL_CODE = 8'h01,
  parameter logic [7:0] DEV_CODE = 8'h02
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Monitored quantities.
  input wire logic overload_i,
  input wire logic [31:0] deviation_i,
  input wire logic net_bus_err_i,
  input wire logic driver_ac_i,
  input wire logic motor_ac_i,
  input wire logic motor_small_frame_i,
  input wire logic supply_48v_i,
  input wire logic [15:0] driver_temp_i,
  input wire logic [15:0] motor_temp_i,
  input wire logic [15:0] speed_i,
  input wire logic [15:0] voltage_i,
  input wire logic [31:0] trip_i,
  input wire logic [31:0] odo_i,
  input wire logic load_tick_i,
  input wire logic [USR_SRC_N-1:0] out_sig_i,
  input wire logic motion_req_i,
  // Host signals.
  input wire logic fault_clear_i,
  output logic no_fault_o,
  output logic ready_o,
  output logic motion_active_o,
  output logic pulse_accept_ready_o,
  output logic motor_stop_o,
  output logic [7:0] fault_code_o,
  // Advisory outputs.
  output logic [NADV-1:0] advisory_flag_o,
  output logic advisory_o,
  output logic led_red_o,
  output logic led_green_o
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] cfg_q [NCFG];
  logic [31:0] rd_data;
  logic [NCFG-1:0] hit;
  logic [TW-1:0] tick_cnt_q;
  logic [15:0] ovl_cnt_q;
  logic [14:0] div_cnt_q;
  logic [31:0] acc_q;
  logic mact_q;
  logic [7:0] fault_code_q;
  aim_fault_state_e state_q;
  logic [NADV-1:0] adv_cond;
  logic [NADV-1:0] adv_reflect;

  // Bus decode.
  wire [IDX_W-1:0] idx = wb_adr_i[IDX_W+1:2];
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire [31:0] wr_merged = wb_merge(32'h0, wb_dat_i, wb_sel_i);
  wire st_clr_wr = wr & (idx == IDX_STATUS);
  wire [NADV-1:0] sw_clr =
    st_clr_wr ? wr_merged[ST_ADV_LSB +: NADV] : {NADV{1'b0}};

  for (genvar k = 0; k < NCFG; k++) begin : g_hit
    assign hit[k] = (idx == CFG_IDX[k]);
  end

  wire fault_q = (state_q == ST_FAULT);
  wire [31:0] status_w = {4'h0, advisory_flag_o, 7'h0, fault_q,
                          fault_code_q};

  always_comb begin
    rd_data = 32'h0;
    for (int k = 0; k < NCFG; k++) begin
      if (hit[k]) begin
        rd_data = cfg_q[k];
      end
    end
    if (idx == IDX_STATUS) begin
      rd_data = status_w;
    end
    if (idx == IDX_LOAD) begin
      rd_data = acc_q;
    end
  end

  // One wait state; unmapped indices read zero and ignore writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NCFG; k++) begin
        cfg_q[k] <= CFG_RST[k];
      end
    end else begin
      for (int k = 0; k < NCFG; k++) begin
        if (wr && hit[k]) begin
          cfg_q[k] <= wb_merge(cfg_q[k], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Tenth-second time base.
  wire tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !overload_i) begin
      ovl_cnt_q <= 16'h0;
    end else if (tick && ovl_cnt_q != 16'hffff) begin
      ovl_cnt_q <= ovl_cnt_q + 16'h1;
    end
  end

  // Fault causes.
  // overload limit compare.
  wire ovl_cause = overload_i &
    at_or_above({16'h0, ovl_cnt_q}, cfg_q[S_OVL_FLT]);
  wire dev_cause = at_or_above(deviation_i, cfg_q[S_DEV_FLT]);
  wire net_cause = net_bus_err_i & cfg_q[S_NET_EN][0];
  wire combo_cause = (motor_ac_i != driver_ac_i) |
    (!driver_ac_i & motor_small_frame_i & supply_48v_i);
  wire any_cause = ovl_cause | dev_cause | net_cause | combo_cause;
  wire [7:0] cause_code = combo_cause ? CODE_COMBO :
                          net_cause ? CODE_NET :
                          ovl_cause ? OVL_CODE : DEV_CODE;

  // fault clear handshake; a live cause keeps the fault set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      fault_code_q <= 8'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (any_cause) begin
            state_q <= ST_FAULT;
            fault_code_q <= cause_code;
          end
        end
        ST_FAULT: begin
          if (fault_clear_i && !any_cause) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // outputs depend on faults only (motion_active_o also on motion_req_i), never on advisories.
  assign no_fault_o = !fault_q;
  assign ready_o = !fault_q;
  assign pulse_accept_ready_o = !fault_q;
  assign motion_active_o = motion_req_i & !fault_q;
  assign motor_stop_o = fault_q;
  assign fault_code_o = fault_code_q;

  // accumulated load with divisor and auto zero.
  wire [14:0] div_raw = cfg_q[S_LOAD_DIV][14:0];
  wire [14:0] div_eff = (div_raw == 15'h0) ? 15'h1 : div_raw;
  wire mact_rise = motion_active_o & !mact_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mact_q <= 1'b0;
      div_cnt_q <= 15'h0;
      acc_q <= 32'h0;
    end else begin
      mact_q <= motion_active_o;
      if (mact_rise && cfg_q[S_LOAD_ZERO][0]) begin
        div_cnt_q <= 15'h0;
        acc_q <= 32'h0;
      end else if (load_tick_i) begin
        if (div_cnt_q + 15'h1 >= div_eff) begin
          div_cnt_q <= 15'h0;
          if (acc_q != 32'hffffffff) begin
            acc_q <= acc_q + 32'h1;
          end
        end else begin
          div_cnt_q <= div_cnt_q + 15'h1;
        end
      end
    end
  end

  // Advisory causes.
  wire [31:0] ov_lim = driver_ac_i ? cfg_q[S_AC_OV] : cfg_q[S_DC_OV];
  wire [31:0] uv_lim = driver_ac_i ? cfg_q[S_AC_UV] : cfg_q[S_DC_UV];
  wire [6:0] usr_sel = cfg_q[S_USR_SEL][6:0];
  // selected source; codes from 128 read as constant off.
  wire usr_sig = (cfg_q[S_USR_SEL] < 32'h80) & out_sig_i[usr_sel];

  assign adv_cond[A_USR] = usr_sig ^ cfg_q[S_USR_INV][0];
  assign adv_cond[A_DEV] = at_or_above(deviation_i, cfg_q[S_DEV_ADV]);
  assign adv_cond[A_DRV] =
    at_or_above({16'h0, driver_temp_i}, cfg_q[S_DRV_TMP]);
  assign adv_cond[A_MTR] =
    at_or_above({16'h0, motor_temp_i}, cfg_q[S_MTR_TMP]);
  assign adv_cond[A_OV] = at_or_above({16'h0, voltage_i}, ov_lim);
  assign adv_cond[A_UV] = at_or_above(uv_lim, {16'h0, voltage_i});
  assign adv_cond[A_OLT] = overload_i &
    at_or_above({16'h0, ovl_cnt_q}, cfg_q[S_OL_TIME]);
  assign adv_cond[A_SPD] = (cfg_q[S_SPEED] != 32'h0) &
    at_or_above({16'h0, speed_i}, cfg_q[S_SPEED]);
  assign adv_cond[A_LDA] = at_or_above(acc_q, cfg_q[S_LOAD_A]);
  assign adv_cond[A_LDB] = at_or_above(acc_q, cfg_q[S_LOAD_B]);
  assign adv_cond[A_TRIP] = (cfg_q[S_TRIP] != 32'h0) &
    at_or_above(trip_i, cfg_q[S_TRIP]);
  assign adv_cond[A_ODO] = (cfg_q[S_ODO] != 32'h0) &
    at_or_above(odo_i, cfg_q[S_ODO]);

  // per-event flags with action and auto clear.
  for (genvar k = 0; k < NADV; k++) begin : g_adv
    aim_advisory_flag u_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(adv_cond[k]),
      .action_i(cfg_q[S_ADV_ACT][k]),
      .auto_clear_i(cfg_q[S_ADV_AUTO][0]),
      .clear_i(sw_clr[k]),
      .flag_o(advisory_flag_o[k]),
      .reflect_o(adv_reflect[k])
    );
  end

  assign advisory_o = |adv_reflect;

  // double blink while any reflected advisory stands.
  aim_led_blink u_led (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .fault_i(fault_q),
    .blink_i(advisory_o),
    .led_red_o(led_red_o),
    .led_green_o(led_green_o)
  );

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ovl_fault: assert property (
    (!fault_q && tick && overload_i &&
     ({16'h0, ovl_cnt_q} + 32'h1 == cfg_q[S_OVL_FLT])) ##1 overload_i
    |=> fault_q)
    else $error("Overload fault not raised at its limit.");

  a_dev_fault: assert property (
    (!fault_q && at_or_above(deviation_i, cfg_q[S_DEV_FLT]))
    |=> fault_q)
    else $error("Deviation fault not raised.");

  a_net_masked: assert property (
    (!fault_q && !cfg_q[S_NET_EN][0] && !ovl_cause && !dev_cause &&
     !combo_cause) |=> !fault_q)
    else $error("Disabled network fault still raised.");

  a_combo_code: assert property (
    (!fault_q && motor_ac_i != driver_ac_i)
    |=> fault_q && fault_code_o == CODE_COMBO)
    else $error("Supply mismatch did not give code 45h.");

  a_small_frame: assert property (
    (!fault_q && !driver_ac_i && !motor_ac_i && motor_small_frame_i &&
     supply_48v_i) |=> fault_q && fault_code_o == CODE_COMBO)
    else $error("Small frame at 48 V did not fault.");

  a_fault_outs: assert property (
    $rose(motor_stop_o) |-> !no_fault_o && !motion_active_o &&
    !pulse_accept_ready_o)
    else $error("Fault did not drop status outputs together.");

  a_fault_clear: assert property (
    (fault_q && fault_clear_i && !any_cause)
    |=> no_fault_o && ready_o && pulse_accept_ready_o)
    else $error("Fault clear did not restore outputs.");

  a_fault_hold: assert property (
    (fault_q && !fault_clear_i) |=> fault_q)
    else $error("Fault cleared without clear input.");

  a_speed_flag: assert property (
    (adv_cond[A_SPD] && cfg_q[S_SPEED] != 32'h0)
    |=> advisory_flag_o[A_SPD])
    else $error("Speed advisory flag not raised.");

  a_reflect_on: assert property (
    (adv_cond[A_MTR] && cfg_q[S_ADV_ACT][A_MTR]) |=> advisory_o)
    else $error("Reflected advisory missing on common output.");

  a_no_reflect: assert property (
    (cfg_q[S_ADV_ACT][NADV-1:0] == 12'h0) |-> !advisory_o)
    else $error("Common output raised with all actions zero.");

  a_motion_kept: assert property (
    (!fault_q && motion_req_i && |advisory_flag_o)
    |-> motion_active_o && !motor_stop_o)
    else $error("Advisory disturbed motion.");

  a_load_zero: assert property (
    (mact_rise && cfg_q[S_LOAD_ZERO][0]) |=> acc_q == 32'h0)
    else $error("Accumulated load not zeroed at motion start.");

  a_auto_clear: assert property (
    (cfg_q[S_ADV_AUTO][0] && advisory_flag_o[A_DRV] && !adv_cond[A_DRV])
    |=> !advisory_flag_o[A_DRV])
    else $error("Advisory flag not auto cleared.");

endmodule : aim_alarm_info_monitor

// >>> aim_host_model.sv
module aim_host_model #(
  parameter int SLOW_CYC = 3
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Test control.
  input wire logic clear_req_i,
  output logic done_o,
  // Device side.
  input wire logic no_fault_i,
  output logic fault_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  // A slow host is the harder case: the fault stays latched meanwhile.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_clear_o <= 1'b0;
      done_o <= 1'b0;
      wait_q <= 0;
    end else if (fault_clear_o) begin
      if (no_fault_i) begin
        fault_clear_o <= 1'b0;
        done_o <= 1'b1;
      end
    end else if (clear_req_i && !done_o) begin
      if (wait_q >= SLOW_CYC) begin
        fault_clear_o <= 1'b1;
        wait_q <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
    end else if (!clear_req_i) begin
      done_o <= 1'b0;
    end
  end
endmodule : aim_host_model

// >>> aim_alarm_info_monitor_tb.sv
module aim_alarm_info_monitor_tb
  import aim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, deviation_i, trip_i, odo_i, q;
  logic overload_i, net_bus_err_i, driver_ac_i, motor_ac_i, motion_req_i;
  logic motor_small_frame_i, supply_48v_i, load_tick_i, fault_clear_i;
  logic [15:0] driver_temp_i, motor_temp_i, speed_i, voltage_i;
  logic [USR_SRC_N-1:0] out_sig_i;
  logic no_fault_o, ready_o, motion_active_o, pulse_accept_ready_o;
  logic motor_stop_o, advisory_o, led_red_o, led_green_o, req, done;
  logic [7:0] fault_code_o;
  logic [NADV-1:0] advisory_flag_o;
  int err_count, checks_done, cycles, lit;

  aim_alarm_info_monitor #(.TICK_CYCLES(8)) u_aim_alarm_info_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .overload_i(overload_i), .deviation_i(deviation_i),
    .net_bus_err_i(net_bus_err_i), .driver_ac_i(driver_ac_i),
    .motor_ac_i(motor_ac_i), .motor_small_frame_i(motor_small_frame_i),
    .supply_48v_i(supply_48v_i), .driver_temp_i(driver_temp_i),
    .motor_temp_i(motor_temp_i), .speed_i(speed_i), .voltage_i(voltage_i),
    .trip_i(trip_i), .odo_i(odo_i), .load_tick_i(load_tick_i),
    .out_sig_i(out_sig_i), .motion_req_i(motion_req_i),
    .fault_clear_i(fault_clear_i), .no_fault_o(no_fault_o),
    .ready_o(ready_o), .motion_active_o(motion_active_o),
    .pulse_accept_ready_o(pulse_accept_ready_o),
    .motor_stop_o(motor_stop_o), .fault_code_o(fault_code_o),
    .advisory_flag_o(advisory_flag_o), .advisory_o(advisory_o),
    .led_red_o(led_red_o), .led_green_o(led_green_o));

  aim_host_model u_aim_host_model (.clk_i(clk_i), .rst_i(rst_i),
    .clear_req_i(req), .done_o(done), .no_fault_i(no_fault_o),
    .fault_clear_o(fault_clear_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // A hang is counted as a mismatch rather than left to run on.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic wb(input logic we, input logic [15:0] idx,
                    input logic [31:0] d, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    chk({31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0, 4'hf);
    chk(q, exp);
  endtask : rd

  task automatic faulted(input logic [7:0] code);
    step(4);
    chk({no_fault_o, ready_o, pulse_accept_ready_o, motor_stop_o}, 4'h1);
    chk({motion_active_o, fault_code_o}, {1'b0, code});
  endtask : faulted

  // Host stops motion first, then runs the clear handshake.
  task automatic clr();
    int n;
    n = 0;
    step(1);
    motion_req_i <= 1'b0;
    req <= 1'b1;
    while (done !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    req <= 1'b0;
    step(1);
    chk({no_fault_o, ready_o, pulse_accept_ready_o, motor_stop_o}, 4'he);
  endtask : clr

  task automatic t_regs();
    for (int i = 0; i < NCFG; i++) rd(CFG_IDX[i], CFG_RST[i]);
    wr(16'h1000, 32'h5a5a5a5a);
    rd(16'h1000, 32'h0);
    wb(1'b1, 16'h0180, 32'haabbccdd, 4'h1);
    rd(16'h0180, 32'hdd);
    wr(16'h0180, 32'h32);
    $display("test regs done");
  endtask : t_regs

  task automatic t_faults();
    net_bus_err_i <= 1'b1;
    faulted(8'h81);
    net_bus_err_i <= 1'b0;
    clr();
    wr(16'h6188, 32'h0);
    net_bus_err_i <= 1'b1;
    step(4);
    chk({31'h0, no_fault_o}, 32'h1);
    step(1);
    net_bus_err_i <= 1'b0;
    wr(16'h6188, 32'h1);
    driver_ac_i <= 1'b1;
    faulted(CODE_COMBO);
    driver_ac_i <= 1'b0;
    clr();
    motor_small_frame_i <= 1'b1;
    supply_48v_i <= 1'b1;
    faulted(CODE_COMBO);
    supply_48v_i <= 1'b0;
    clr();
    deviation_i <= 32'd299;
    step(4);
    chk({31'h0, no_fault_o}, 32'h1);
    step(1);
    deviation_i <= 32'd300;
    faulted(8'h02);
    deviation_i <= 32'd0;
    clr();
    wr(16'h0180, 32'h2);
    overload_i <= 1'b1;
    step(9);
    chk({31'h0, no_fault_o}, 32'h1);
    step(8);
    faulted(8'h01);
    chk({24'h0, fault_code_o}, 32'h01);
    overload_i <= 1'b0;
    clr();
    $display("test faults done");
  endtask : t_faults

  // Counts lit cycles of the red LED over a whole blink pattern.
  task automatic adv_speed(input logic [31:0] act, input logic exp_c);
    wr(16'h01c0, act);
    motion_req_i <= 1'b1;
    speed_i <= 16'd100;
    step(4);
    chk({advisory_flag_o[7], advisory_o}, {1'b1, exp_c});
    chk({motion_active_o, motor_stop_o}, 2'b10);
    lit = 0;
    repeat (80) begin
      @(posedge clk_i);
      lit += led_red_o;
    end
    chk(lit > 0, exp_c);
    speed_i <= 16'd99;
    step(4);
    chk({advisory_flag_o[7], advisory_o}, 2'b00);
  endtask : adv_speed

  task automatic t_adv();
    wr(16'h01a2, 32'd100);
    adv_speed(32'hfff, 1'b1);
    adv_speed(32'hf7f, 1'b0);
    wr(16'h01c0, 32'hfff);
    wr(16'h01bc, 32'd5);
    out_sig_i <= 128'h20;
    step(4);
    chk({31'h0, advisory_flag_o[0]}, 32'h1);
    wr(16'h01bd, 32'h1);
    step(3);
    chk({31'h0, advisory_flag_o[0]}, 32'h0);
    wr(16'h01bc, 32'd128);
    driver_temp_i <= 16'd85;
    motor_temp_i <= 16'd84;
    step(4);
    chk({30'h0, advisory_flag_o[3:2]}, 32'h1);
    chk({31'h0, advisory_flag_o[0]}, 32'h1);
    step(1);
    motor_temp_i <= 16'd85;
    step(4);
    chk({30'h0, advisory_flag_o[3:2]}, 32'h3);
    wr(16'h01bd, 32'h0);
    driver_temp_i <= 16'd25;
    motor_temp_i <= 16'd25;
    wr(16'h01af, 32'd10);
    trip_i <= 32'd10;
    odo_i <= 32'hffff;
    step(4);
    chk({30'h0, advisory_flag_o[11:10]}, 32'h1);
    $display("test advisory done");
  endtask : t_adv

  // Motion is dropped first so that the later request is a fresh start.
  task automatic t_load();
    motion_req_i <= 1'b0;
    wr(16'h01b4, 32'd2);
    repeat (8) begin
      step(1);
      load_tick_i <= 1'b1;
      step(1);
      load_tick_i <= 1'b0;
    end
    step(4);
    chk({30'h0, advisory_flag_o[9:8]}, 32'h1);
    rd(IDX_LOAD, 32'd4);
    motion_req_i <= 1'b1;
    step(5);
    chk({30'h0, advisory_flag_o[9:8]}, 32'h0);
    $display("test load done");
  endtask : t_load

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    {overload_i, net_bus_err_i, driver_ac_i, motor_ac_i} = '0;
    {motor_small_frame_i, supply_48v_i, load_tick_i, motion_req_i} = '0;
    {deviation_i, trip_i, odo_i, out_sig_i, speed_i} = '0;
    driver_temp_i = 16'd25;
    motor_temp_i = 16'd25;
    voltage_i = 16'd300;
    req = 1'b0;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    rst_i = 1'b1;
    step(2);
    rst_i <= 1'b0;
    t_regs();
    wr(16'h01b1, 32'd4);
    wr(16'h01b2, 32'd8);
    t_faults();
    t_adv();
    t_load();
    stop_test();
  end
endmodule : aim_alarm_info_monitor_tb
